/* pkg/lci_pkg.sv */
// lci_pkg: register map, field positions, codes and reset values
// assumes an apb slave with 32-bit data, one register per aligned word
package lci_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_INTERRUPT_CAUSE_STATUS_OFS = 8'h00;
  localparam logic [7:0] ADDR_EXTENDED_CAUSE_REGISTER_OFS = 8'h04;
  localparam logic [7:0] ADDR_IND_OFS  = 8'h08;
  localparam logic [7:0] ADDR_CMD_OFS  = 8'h0c;
  localparam logic [7:0] ADDR_SPC_OFS  = 8'h10;
  localparam logic [7:0] ADDR_ST2_OFS  = 8'h14;
  localparam logic [7:0] ADDR_TE1_OFS  = 8'h18;
  localparam logic [7:0] ADDR_TE2_OFS  = 8'h1c;
  localparam logic [7:0] ADDR_LCC_OFS  = 8'h20;
  localparam logic [7:0] ADDR_LERR_OFS = 8'h24;
  // interrupt cause status bit positions
  localparam int BIT_RME = 7;
  localparam int BIT_RPF = 6;
  localparam int BIT_RSC = 5;
  localparam int BIT_XPR = 4;
  localparam int BIT_TIN = 3;
  localparam int BIT_CIC = 2;
  localparam int BIT_SIN = 1;
  localparam int BIT_EXI = 0;
  // extended cause bit positions
  localparam int BIT_SOV = 4;
  localparam int BIT_MOS = 3;
  localparam int BIT_SAW = 2;
  localparam int BIT_WOV = 1;
  localparam int BIT_PCE = 0;
  // link error bit positions
  localparam int BIT_RDO = 3;
  localparam int BIT_RAB = 2;
  localparam int BIT_XDU = 1;
  localparam int BIT_XMR = 0;
  // serial port config bits
  localparam int BIT_SPU = 0;
  localparam int BIT_TLP = 1;
  // second status register bits
  localparam int BIT_WFA = 0;
  localparam int BIT_TIMER_RECOVERY_STATE = 1;
  // command and indication codes (4 bits)
  localparam logic [3:0] CMD_TIM = 4'h0;
  localparam logic [3:0] CMD_RS  = 4'h1;
  localparam logic [3:0] CMD_ARL = 4'h9;
  localparam logic [3:0] CMD_AR  = 4'h8;
  localparam logic [3:0] CMD_DIU = 4'hf;
  localparam logic [3:0] CMD_DEA = 4'h3;
  localparam logic [3:0] IND_DR  = 4'h0;
  localparam logic [3:0] IND_EI  = 4'h6;
  localparam logic [3:0] IND_PU  = 4'h7;
  localparam logic [3:0] IND_AI  = 4'hc;
  localparam logic [3:0] IND_DC  = 4'hf;
  localparam logic [3:0] IND_RST = 4'hf;
  localparam logic [7:0] TEI_RST = 8'hff;
  localparam logic [7:0] ZERO8   = 8'h00;
  // layer-1 response delay in cycles
  localparam int L1_DLY_CYC = 4;
endpackage

/* pkg/lci_ev_if.sv */
// lci_ev_if: event pulses and clear mask for one sticky cause group
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface lci_ev_if;
  logic [7:0] set_ev;
  logic [7:0] clr;
  logic [7:0] flags;
  modport owner (input set_ev, input clr, output flags);
  modport user  (output set_ev, output clr, input flags);
endinterface

/* src/lci_sticky.sv */
// lci_sticky: 8 sticky cause flags, set wins over clear
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module lci_sticky (
  input  wire logic clock,
  input  wire logic nrst,
  lci_ev_if.owner   ev
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  always_comb begin
    flags_nxt = (flags_r & ~ev.clr) | ev.set_ev;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign ev.flags = flags_r;
endmodule

/* src/lci_top.sv */
// lci_top: layer-1 command/indication control and cause registers
// assumes an apb master on clock; event inputs are asynchronous pins
// Contract
// [R1] cause status bits: 80 rme, 40 rpf, 20 rsc, 10 xpr, 08 tin.
// [R2] every layer-1 state change raises indication change.
// [R3] host writes activate request only when layer 1 not active.
// [R4] host writes deactivation only when not already deactivated.
// [R5] host writes activate-loop code, then follows indication changes.
// [R6] host checks clocks running before power-up in terminal mode.
// [R7] host sets power-up bit, sends timing, waits powered-up, clears.
// [R8] host init: reset sequence, timing mode 0, bus address.
// [R9] host sends reset, waits bounded for new state, then release.
// [R10] host flags defect when post-reset indication never arrives.
// [R11] host reads indication; on pending deactivation sends release.
// [R12] on activation indication host confirms with activate request.
// [R13] host reports decoded layer-1 state after each change.
// [R14] host dispatches causes to direct, receive and layer-1 handlers.
// [R15] extended bit summarises separate extended cause register.
// [R16] link errors rdo, rab, xdu, xmr are distinct causes.
// [R17] timer-recovery and waiting-ack bits show outstanding ack.
// [R18] host reports missing ack on mode switch while outstanding.
// [R19] host link init sets mode, modulo, timer, broadcast tei.
// [R20] host writes tei into first or second tei register.
// [R21] host bounds post-reset wait by configurable cycle count; lci_host wait_ind uses a fixed bound of 32 polls.
`timescale 1ns/1ps
module lci_top
  import lci_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  cause_pins,
  input  wire logic [4:0]  ext_pins,
  input  wire logic [3:0]  link_err_pins,
  input  wire logic [1:0]  ack_state_pins,
  input  wire logic        clocks_present,
  output logic      [3:0]  command_out,
  output logic             command_stb,
  output logic      [7:0]  serial_port_config,
  output logic      [7:0]  link_config
);
  import lci_pkg::*;

  lci_ev_if cause_ev ();
  lci_ev_if ext_ev ();
  lci_ev_if lerr_ev ();

  lci_sticky u_cause (.clock(clock), .nrst(nrst), .ev(cause_ev));
  lci_sticky u_ext   (.clock(clock), .nrst(nrst), .ev(ext_ev));
  lci_sticky u_lerr  (.clock(clock), .nrst(nrst), .ev(lerr_ev));

  // three-stage pin synchronisers
  logic [19:0] pin_s1_r;
  logic [19:0] pin_s2_r;
  logic [19:0] pin_s3_r;
  logic [19:0] pin_seen_r;
  logic [19:0] pin_seen_nxt;
  logic [19:0] pin_nxt;
  logic [19:0] pin_agree;
  logic [19:0] pin_rise;

  // an edge counts only once stages two and three agree
  always_comb begin
    pin_nxt = {cause_pins, ext_pins, link_err_pins, ack_state_pins,
               clocks_present};
    pin_agree = ~(pin_s2_r ^ pin_s3_r);
    pin_rise = pin_agree & pin_s3_r & ~pin_seen_r;
    pin_seen_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_seen_r);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_s3_r   <= '0;
      pin_seen_r <= '0;
    end else begin
      pin_s1_r   <= pin_nxt;
      pin_s2_r   <= pin_s1_r;
      pin_s3_r   <= pin_s2_r;
      pin_seen_r <= pin_seen_nxt;
    end
  end

  // registers
  logic [3:0]  cmd_r;
  logic [3:0]  cmd_nxt;
  logic        cmd_stb_r;
  logic        cmd_stb_nxt;
  logic [7:0]  spc_r;
  logic [7:0]  spc_nxt;
  logic [7:0]  te1_r;
  logic [7:0]  te1_nxt;
  logic [7:0]  te2_r;
  logic [7:0]  te2_nxt;
  logic [7:0]  lcc_r;
  logic [7:0]  lcc_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rdy_r;
  logic        rdy_nxt;
  logic        err_r;
  logic        err_nxt;

  // layer-1 state model driven by commands
  logic [3:0]  ind_r;
  logic [3:0]  ind_nxt;
  logic [3:0]  tgt_r;
  logic [3:0]  tgt_nxt;
  logic [2:0]  dly_r;
  logic [2:0]  dly_nxt;
  logic        ind_chg;

  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [7:0] ev_l1;

  always_comb begin
    acc = psel && penable && !rdy_r;
    wr  = acc && pwrite;
    rd  = acc && !pwrite;
    hit = (paddr[1:0] == 2'b00) && (paddr <= ADDR_LERR_OFS);
  end

  // command decode into expected indication
  always_comb begin
    tgt_nxt = tgt_r;
    dly_nxt = dly_r;
    ind_nxt = ind_r;
    ind_chg = 1'b0;
    if (wr && paddr == ADDR_CMD_OFS) begin
      dly_nxt = 3'(L1_DLY_CYC);
      case (pwdata[3:0])
        CMD_RS:  tgt_nxt = IND_EI;
        CMD_TIM: tgt_nxt = IND_PU;
        CMD_AR:  tgt_nxt = IND_AI;
        CMD_ARL: tgt_nxt = IND_AI;
        CMD_DIU: tgt_nxt = IND_DC;
        CMD_DEA: tgt_nxt = IND_DR;
        default: tgt_nxt = ind_r;
      endcase
    end else if (dly_r != 3'd0) begin
      dly_nxt = dly_r - 3'd1;
      if (dly_r == 3'd1 && tgt_r != ind_r) begin
        ind_nxt = tgt_r;
        ind_chg = 1'b1; // R2
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ind_r <= IND_RST;
      tgt_r <= IND_RST;
      dly_r <= 3'd0;
    end else begin
      ind_r <= ind_nxt;
      tgt_r <= tgt_nxt;
      dly_r <= dly_nxt;
    end
  end

  // sticky cause wiring
  always_comb begin
    ev_l1 = 8'h00;
    ev_l1[BIT_CIC] = ind_chg; // R2
    // pin vector: cause 19:12, extended 11:7, link 6:3, ack 2:1
    ext_ev.set_ev  = {3'b000, pin_rise[11:7]}; // R15
    lerr_ev.set_ev = {4'h0, pin_rise[6:3]}; // R16
    // bit 2 comes from layer 1, bit 0 is formed from extended flags
    cause_ev.set_ev = {pin_rise[19:15], 3'b000} | ev_l1 |
                      {6'h00, pin_rise[13], 1'b0}; // R1
    ext_ev.clr  = 8'h00;
    lerr_ev.clr = 8'h00;
    cause_ev.clr = 8'h00;
    if (rd && paddr == ADDR_EXTENDED_CAUSE_REGISTER_OFS) begin
      ext_ev.clr = 8'hff;
    end
    if (rd && paddr == ADDR_LERR_OFS) begin
      lerr_ev.clr = 8'hff;
    end
    if (rd && paddr == ADDR_INTERRUPT_CAUSE_STATUS_OFS) begin
      cause_ev.clr = 8'hff;
      cause_ev.clr[BIT_EXI] = 1'b0;
    end
  end

  // apb register file
  always_comb begin
    cmd_nxt = cmd_r;
    cmd_stb_nxt = 1'b0;
    spc_nxt = spc_r;
    te1_nxt = te1_r;
    te2_nxt = te2_r;
    lcc_nxt = lcc_r;
    rdata_nxt = 32'h0000_0000;
    rdy_nxt = acc;
    err_nxt = acc && !hit;
    if (wr && hit) begin
      case (paddr)
        ADDR_CMD_OFS: begin
          cmd_nxt = pwdata[3:0];
          cmd_stb_nxt = 1'b1;
        end
        ADDR_SPC_OFS: spc_nxt = pwdata[7:0];
        ADDR_TE1_OFS: te1_nxt = pwdata[7:0];
        ADDR_TE2_OFS: te2_nxt = pwdata[7:0];
        ADDR_LCC_OFS: lcc_nxt = pwdata[7:0];
        default: err_nxt = 1'b1;
      endcase
    end
    if (rd && hit) begin
      case (paddr)
        ADDR_INTERRUPT_CAUSE_STATUS_OFS: begin
          rdata_nxt[7:0] = cause_ev.flags;
          rdata_nxt[BIT_EXI] = |ext_ev.flags; // R15
        end
        ADDR_EXTENDED_CAUSE_REGISTER_OFS: rdata_nxt[7:0] = ext_ev.flags;
        ADDR_IND_OFS:  rdata_nxt[7:0] = {3'b000, pin_s3_r[0], ind_r};
        ADDR_CMD_OFS:  rdata_nxt[7:0] = {4'h0, cmd_r};
        ADDR_SPC_OFS:  rdata_nxt[7:0] = spc_r;
        ADDR_ST2_OFS:  rdata_nxt[7:0] = {6'h00, pin_s3_r[2:1]}; // R17
        ADDR_TE1_OFS:  rdata_nxt[7:0] = te1_r;
        ADDR_TE2_OFS:  rdata_nxt[7:0] = te2_r;
        ADDR_LCC_OFS:  rdata_nxt[7:0] = lcc_r;
        ADDR_LERR_OFS: rdata_nxt[7:0] = lerr_ev.flags; // R16
        default: err_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmd_r     <= CMD_TIM;
      cmd_stb_r <= 1'b0;
      spc_r     <= ZERO8;
      te1_r     <= TEI_RST;
      te2_r     <= TEI_RST;
      lcc_r     <= ZERO8;
      rdata_r   <= 32'h0000_0000;
      rdy_r     <= 1'b0;
      err_r     <= 1'b0;
    end else begin
      cmd_r     <= cmd_nxt;
      cmd_stb_r <= cmd_stb_nxt;
      spc_r     <= spc_nxt;
      te1_r     <= te1_nxt;
      te2_r     <= te2_nxt;
      lcc_r     <= lcc_nxt;
      rdata_r   <= rdata_nxt;
      rdy_r     <= rdy_nxt;
      err_r     <= err_nxt;
    end
  end

  always_comb begin
    prdata = rdata_r;
    pready = rdy_r;
    pslverr = err_r;
    command_out = cmd_r;
    command_stb = cmd_stb_r;
    serial_port_config = spc_r;
    link_config = lcc_r;
  end
endmodule

/* verification/lci_props.sv */
// lci_props: bus timing and register behaviour seen at lci_top ports
// assumes bound to lci_top, one clock, nrst synchronous
`timescale 1ns/1ps
module lci_props
  import lci_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  ack_state_pins,
  input wire logic [3:0]  command_out,
  input wire logic        command_stb,
  input wire logic [7:0]  serial_port_config
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence wr_s(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  property p_cmd;
    logic [3:0] c;
    (wr_s(ADDR_CMD_OFS), c = pwdata[3:0]) |->
      (command_stb && command_out == c);
  endproperty
  property p_spc;
    logic [7:0] v;
    (wr_s(ADDR_SPC_OFS), v = pwdata[7:0]) |=> serial_port_config == v;
  endproperty
  chk_one_wait: assert property (acc_s |=> pready)
    else $error("pready missing after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_map: assert property (psel && pready |->
    pslverr == (paddr > ADDR_LERR_OFS || paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  chk_upper_zero: assert property (psel && pready && !pwrite |->
    prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_cmd_strobe: assert property (p_cmd)
    else $error("command strobe or code wrong");
  chk_stb_pulse: assert property (command_stb |=> !command_stb)
    else $error("command strobe too long");
  chk_spc_copy: assert property (p_spc)
    else $error("serial config copy wrong");
  chk_ack_bits: assert property (psel && pready && !pwrite &&
    paddr == ADDR_ST2_OFS && ack_state_pins == $past(ack_state_pins, 4)
    |-> prdata[BIT_TIMER_RECOVERY_STATE] == ack_state_pins[1]
        && prdata[BIT_WFA] == ack_state_pins[0])
    else $error("ack state bits wrong");
endmodule
bind lci_top lci_props lci_props_i (.clock, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .ack_state_pins,
  .command_out, .command_stb, .serial_port_config);

/* verification/lci_host.sv */
// lci_host: host driver model, apb master plus layer-1 command steps
// assumes the bench monitor pops exp_q on each read answer
`timescale 1ns/1ps
module lci_host
  import lci_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  logic [64:0] exp_q[$];
  logic [31:0] rdv;
  int          fails = 0;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic e);
    int n;
    if (!w)
      exp_q.push_back({e, m, d});
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 16);
    if (n == 16) fails++;
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll indication, bounded; miss marks layer 1 defective
  task wait_ind(input logic [3:0] code);
    int k;
    for (k = 0; k < 32; k++) begin
      xfer(1'b0, ADDR_IND_OFS, 32'h0, 32'h0, 1'b0);
      if (rdv[3:0] === code) break;
    end
    if (k == 32) fails++;
  endtask
  task send(input logic [3:0] c, input logic [3:0] ind);
    xfer(1'b1, ADDR_CMD_OFS, {28'h0, c}, 32'h0, 1'b0);
    wait_ind(ind);
  endtask
endmodule

/* verification/lci_tb_top.sv */
// lci_tb_top: self-checking bench for lci_top
// assumes lci_host drives apb, monitor here checks every read answer
`timescale 1ns/1ps
module lci_tb_top;
  import lci_pkg::*;
  logic        clock, nrst, clocks_present;
  logic [7:0]  cause_pins, seed = 8'h02;
  logic [4:0]  ext_pins;
  logic [3:0]  link_err_pins;
  logic [1:0]  ack_state_pins;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  logic [64:0] ent;
  logic [3:0]  cmds [6], inds [6];
  int          n_mismatch = 0, num_checks = 0, i, j;
  lci_top lci_top_i (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cause_pins(cause_pins), .ext_pins(ext_pins),
    .link_err_pins(link_err_pins), .ack_state_pins(ack_state_pins),
    .clocks_present(clocks_present), .command_out(), .command_stb(),
    .serial_port_config(), .link_config());
  lci_host lci_host_i (.clock(clock), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    lci_host_i.xfer(1'b0, a, d, m, 1'b0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    lci_host_i.xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks,
             n_mismatch + lci_host_i.fails);
    if (n_mismatch + lci_host_i.fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (lci_host_i.fails != 0) results();
    if (psel && pready === 1'b1 && !pwrite && lci_host_i.exp_q.size() > 0) begin
      ent = lci_host_i.exp_q.pop_front();
      num_checks++;
      if (pslverr !== ent[64] || (prdata & ent[63:32]) !== (ent[31:0] & ent[63:32])) begin
        n_mismatch++;
        $display("unexpected %0t read %h at %h", $time, prdata, paddr);
      end
    end
  end
  initial begin
    nrst = 1'b0; clocks_present = 1'b1; cause_pins = 8'h0; ext_pins = 5'h0;
    link_err_pins = 4'h0; ack_state_pins = 2'b00;
    cmds = '{CMD_RS, CMD_AR, CMD_TIM, CMD_ARL, CMD_DEA, CMD_DIU};
    inds = '{IND_EI, IND_AI, IND_PU, IND_AI, IND_DR, IND_DC};
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    rd(ADDR_IND_OFS, 32'h1f, 32'hffffffff);
    rd(ADDR_TE1_OFS, 32'hff, 32'hffffffff);
    for (j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      wr(j ? ADDR_TE2_OFS : ADDR_TE1_OFS, {24'h0, seed});
      rd(j ? ADDR_TE2_OFS : ADDR_TE1_OFS, {24'h0, seed}, 32'hff);
    end
    wr(ADDR_SPC_OFS, 32'h1);
    rd(ADDR_SPC_OFS, 32'h1, 32'hff);
    clocks_present <= 1'b0;
    repeat (6) @(posedge clock);
    rd(ADDR_IND_OFS, 32'h0, 32'h10);
    clocks_present <= 1'b1;
    rd(ADDR_INTERRUPT_CAUSE_STATUS_OFS, 32'h0, 32'h0);
    for (i = 0; i < 5; i++) begin
      cause_pins <= 8'h10 << i;
      ext_pins <= 5'h01 << i;
      link_err_pins <= 4'h1 << i;
      repeat (4) @(posedge clock);
      {cause_pins, ext_pins, link_err_pins} <= '0;
      repeat (4) @(posedge clock);
      rd(ADDR_INTERRUPT_CAUSE_STATUS_OFS, (32'h10 << i) | 32'h1, 32'hf1);
      rd(ADDR_EXTENDED_CAUSE_REGISTER_OFS, 32'h1 << i, 32'hffffffff);
      rd(ADDR_INTERRUPT_CAUSE_STATUS_OFS, 32'h0, 32'h1);
      rd(ADDR_LERR_OFS, (32'h1 << i) & 32'hf, 32'hffffffff);
    end
    for (i = 0; i < 4; i++) begin
      ack_state_pins <= i[1:0];
      repeat (6) @(posedge clock);
      rd(ADDR_ST2_OFS, i, 32'h3);
    end
    lci_host_i.xfer(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    wr(8'h40, 32'h5a);
    rd(ADDR_INTERRUPT_CAUSE_STATUS_OFS, 32'h0, 32'h0);
    for (i = 0; i < 6; i++) begin
      lci_host_i.send(cmds[i], inds[i]);
      rd(ADDR_INTERRUPT_CAUSE_STATUS_OFS, 32'h4, 32'h4);
    end
    results();
  end
endmodule
